// ### design/dmacc_consts.vh
// constants for one dma channel control block: offsets, fields, codes, states
// assumes inclusion by bare name from the design files of this block
// Behaviour
// - code 0000 selects external request pin, dual address mode; reset value.
// - code 0010 selects external pin, single address, memory to acked device.
// - code 0011 selects external pin, single address, acked device to memory.
// - codes 0100-0111 select serial 0/1 receive-full and transmit-empty requests, dual.
// - codes 1000-1011 select timer 0-3 match A requests, dual address mode.
// - 1100 self-generated, 1101 converter done, dual; 0001,1110,1111 illegal.
// - external pin codes usable only on channels 0 and 1.
// - ack phase bit picks read or write cycle for ack; ignored single.
// - ack polarity bit 0 gives active-high ack, 1 active-low.
// - request sense bit 0 detects low level, 1 falling edge.
// - bus mode bit 0 cycle-steal releasing bus, 1 burst.
// - unit size bit 0 byte, 1 sixteen-bit word.
// - with interrupt enable set, end flag raises completion interrupt.
// - end flag sets when count reaches zero on normal completion.
// - end flag stays clear on nmi, address fault or enable abort.
// - end flag clears only by writing 0 after reading 1.
// - while end flag set, channel enable starts nothing.
// - self-generated mode starts once enabled with all flags clear.
// - request starts a unit only when enables set, flags clear.
// - clearing channel enable stops a transfer in progress.
// - reset and standby clear every control field.
// - clearing global enable aborts transfers at once.
// - each unit decrements remaining count by one.
`ifndef DMACC_CONSTS_VH
`define DMACC_CONSTS_VH

`define DMACC_ADDR_W      8
`define DMACC_OFS_CTRL    8'h00
`define DMACC_OFS_COUNT   8'h04

`define DMACC_CTRL_RESET  16'h0000
`define DMACC_COUNT_RESET 16'h0000
`define DMACC_COUNT_ONE   16'h0001

`define DMACC_BIT_DE      0
`define DMACC_BIT_TE      1
`define DMACC_BIT_IE      2
`define DMACC_BIT_TS      3
`define DMACC_BIT_TM      4
`define DMACC_BIT_DS      5
`define DMACC_BIT_AL      6
`define DMACC_BIT_AM      7
`define DMACC_RS_LO       8
`define DMACC_RS_HI       11

`define DMACC_RS_EXT_DUAL 4'h0
`define DMACC_RS_RSV0     4'h1
`define DMACC_RS_EXT_M2D  4'h2
`define DMACC_RS_EXT_D2M  4'h3
`define DMACC_RS_SER0_RX  4'h4
`define DMACC_RS_SER0_TX  4'h5
`define DMACC_RS_SER1_RX  4'h6
`define DMACC_RS_SER1_TX  4'h7
`define DMACC_RS_TMR0     4'h8
`define DMACC_RS_TMR1     4'h9
`define DMACC_RS_TMR2     4'ha
`define DMACC_RS_TMR3     4'hb
`define DMACC_RS_AUTO     4'hc
`define DMACC_RS_CONV     4'hd

`define DMACC_ST_IDLE     2'b00
`define DMACC_ST_RD       2'b01
`define DMACC_ST_WR       2'b10
`define DMACC_ST_SGL      2'b11

`endif

// ### design/dmacc_req_sel.v
// request source selection and detection for one channel
// assumes all request inputs synchronous to mclk; pin request is active low
`include "dmacc_consts.vh"
`default_nettype none

module dmacc_req_sel #(
	parameter EXT_OK = 1
) (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       standby,
	input  wire [3:0] sourceSel,
	input  wire       senseEdge,
	input  wire       extReq_n,
	input  wire [8:0] periphReq,
	input  wire       take,
	output reg        reqValid,
	output reg        srcSingle,
	output reg        srcExt
);

	reg extPrev_ff;
	reg edgePend_ff;
	wire fallSeen;
	wire extLevel;

	// falling edge kept pending until a unit takes it
	assign fallSeen = extPrev_ff & ~extReq_n;
	assign extLevel = senseEdge ? edgePend_ff : ~extReq_n;

	always @(posedge mclk) begin
		if (!rst_n || standby) begin
			extPrev_ff  <= 1'b1;
			edgePend_ff <= 1'b0;
		end else begin
			extPrev_ff <= extReq_n;
			// a new edge in the take cycle is kept, not lost; level sense
			// drops any stale edge so a later switch to edge sense starts clean
			if (fallSeen && senseEdge)
				edgePend_ff <= 1'b1;
			else if (take || !senseEdge)
				edgePend_ff <= 1'b0;
		end
	end

	// decode of the source code into one request
	always @* begin
		reqValid  = 1'b0;
		srcSingle = 1'b0;
		srcExt    = 1'b0;
		case (sourceSel)
			`DMACC_RS_EXT_DUAL: begin
				srcExt   = (EXT_OK != 0);
				reqValid = (EXT_OK != 0) & extLevel;
			end
			`DMACC_RS_EXT_M2D, `DMACC_RS_EXT_D2M: begin
				srcExt    = (EXT_OK != 0);
				srcSingle = 1'b1;
				reqValid  = (EXT_OK != 0) & extLevel;
			end
			`DMACC_RS_SER0_RX: reqValid = periphReq[0];
			`DMACC_RS_SER0_TX: reqValid = periphReq[1];
			`DMACC_RS_SER1_RX: reqValid = periphReq[2];
			`DMACC_RS_SER1_TX: reqValid = periphReq[3];
			`DMACC_RS_TMR0:    reqValid = periphReq[4];
			`DMACC_RS_TMR1:    reqValid = periphReq[5];
			`DMACC_RS_TMR2:    reqValid = periphReq[6];
			`DMACC_RS_TMR3:    reqValid = periphReq[7];
			`DMACC_RS_AUTO:    reqValid = 1'b1;
			`DMACC_RS_CONV:    reqValid = periphReq[8];
			default:           reqValid = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// ### design/dmacc_channel.v
// control and status logic of one dma channel: control register,
// remaining count, request pick-up, unit sequencing, end flag and interrupt
// assumes one clock, synchronous inputs, a one-cycle strobe register port,
// and global enable and abort flags kept by a shared operation register
//
// Strobed register access and the register addresses are this design's own decisions.
`include "dmacc_consts.vh"
`default_nettype none

module dmacc_channel #(
	parameter CH_NUM = 0
) (
	input  wire                     mclk,
	input  wire                     rst_n,
	input  wire                     standby,
	input  wire [`DMACC_ADDR_W-1:0] regAddr,
	input  wire [15:0]              regWdata,
	input  wire                     regWr,
	input  wire                     regRd,
	output reg  [15:0]              regRdata,
	input  wire                     globalXferEnable,
	input  wire                     nmiAbortFlag,
	input  wire                     addrFaultFlag,
	input  wire                     extXferRequest_n,
	input  wire                     serial0RxFullReq,
	input  wire                     serial0TxEmptyReq,
	input  wire                     serial1RxFullReq,
	input  wire                     serial1TxEmptyReq,
	input  wire                     timer0MatchAReq,
	input  wire                     timer1MatchAReq,
	input  wire                     timer2MatchAReq,
	input  wire                     timer3MatchAReq,
	input  wire                     convDoneReq,
	output reg                      extXferAck,
	output reg                      busOwn,
	output reg                      readCycle,
	output reg                      writeCycle,
	output reg                      singleAddr,
	output reg                      wordUnit,
	output reg                      burstHold,
	output reg                      blockDoneIrq
);

	// only channels 0 and 1 have the external pin features
	localparam EXT_OK = (CH_NUM < 2) ? 1 : 0;

	// control fields
	reg  [3:0]  requestSourceSel_ff;
	reg         ackPhaseSel_ff;
	reg         ackPolarity_ff;
	reg         requestSenseSel_ff;
	reg         busHoldSel_ff;
	reg         unitSizeSel_ff;
	reg         completionIrqEnable_ff;
	reg         transferEndFlag_ff;
	reg         channelEnable_ff;
	reg         endReadArmed_ff;
	reg  [15:0] remainingCount_ff;
	reg  [1:0]  state_ff;

	reg  [3:0]  nxt_requestSourceSel;
	reg         nxt_transferEndFlag;
	reg         nxt_endReadArmed;
	reg  [15:0] nxt_remainingCount;
	reg  [1:0]  nxt_state;
	reg         nxt_ack;
	reg  [15:0] nxt_rdata;
	reg         take;
	reg         unitDone;
	reg         lastUnit;

	wire        wrCtrl;
	wire        wrCount;
	wire        rdCtrl;
	wire        rdCount;
	wire        runOk;
	wire        reqValid;
	wire        srcSingle;
	wire        srcExt;
	wire [3:0]  wrSource;
	wire        wrSourceExt;
	wire [15:0] ctrlView;
	wire [8:0]  periphReq;

	// register port decode
	assign wrCtrl  = regWr & (regAddr == `DMACC_OFS_CTRL);
	assign wrCount = regWr & (regAddr == `DMACC_OFS_COUNT);
	assign rdCtrl  = regRd & (regAddr == `DMACC_OFS_CTRL);
	assign rdCount = regRd & (regAddr == `DMACC_OFS_COUNT);

	assign wrSource = regWdata[`DMACC_RS_HI:`DMACC_RS_LO];
	assign wrSourceExt = (wrSource == `DMACC_RS_EXT_DUAL) |
		(wrSource == `DMACC_RS_EXT_M2D) | (wrSource == `DMACC_RS_EXT_D2M);

	// one gate for every start and every unit in flight
	assign runOk = channelEnable_ff & globalXferEnable & ~transferEndFlag_ff &
		~nmiAbortFlag & ~addrFaultFlag;

	assign periphReq = {convDoneReq, timer3MatchAReq, timer2MatchAReq,
		timer1MatchAReq, timer0MatchAReq, serial1TxEmptyReq,
		serial1RxFullReq, serial0TxEmptyReq, serial0RxFullReq};

	// readback image; upper nibble belongs to address logic elsewhere
	assign ctrlView = {4'h0, requestSourceSel_ff, ackPhaseSel_ff,
		ackPolarity_ff, requestSenseSel_ff, busHoldSel_ff, unitSizeSel_ff,
		completionIrqEnable_ff, transferEndFlag_ff, channelEnable_ff};

	dmacc_req_sel #(
		.EXT_OK(EXT_OK)
	) u_req (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.standby   (standby),
		.sourceSel (requestSourceSel_ff),
		.senseEdge (requestSenseSel_ff),
		.extReq_n  (extXferRequest_n),
		.periphReq (periphReq),
		.take      (take),
		.reqValid  (reqValid),
		.srcSingle (srcSingle),
		.srcExt    (srcExt)
	);

	// source write: pin codes refused on channels without the pin
	always @* begin
		nxt_requestSourceSel = requestSourceSel_ff;
		if (wrCtrl && (EXT_OK != 0 || !wrSourceExt))
			nxt_requestSourceSel = wrSource;
	end

	// unit sequencer; a dropped enable or a raised end, nmi or fault flag aborts the unit at once
	always @* begin
		nxt_state = state_ff;
		take      = 1'b0;
		unitDone  = 1'b0;
		case (state_ff)
			`DMACC_ST_IDLE: begin
				if (runOk && reqValid) begin
					take      = 1'b1;
					nxt_state = srcSingle ? `DMACC_ST_SGL : `DMACC_ST_RD;
				end
			end
			`DMACC_ST_RD: begin
				if (!runOk)
					nxt_state = `DMACC_ST_IDLE;
				else
					nxt_state = `DMACC_ST_WR;
			end
			`DMACC_ST_WR, `DMACC_ST_SGL: begin
				if (!runOk) begin
					nxt_state = `DMACC_ST_IDLE;
				end else begin
					unitDone = 1'b1;
					// burst keeps the bus, cycle-steal gives it back a cycle
					if (!lastUnit && busHoldSel_ff && reqValid) begin
						take      = 1'b1;
						nxt_state = srcSingle ? `DMACC_ST_SGL : `DMACC_ST_RD;
					end else begin
						nxt_state = `DMACC_ST_IDLE;
					end
				end
			end
			default: nxt_state = `DMACC_ST_IDLE;
		endcase
	end

	// count; software write wins over the decrement of the same cycle
	always @* begin
		lastUnit = (remainingCount_ff == `DMACC_COUNT_ONE);
		nxt_remainingCount = remainingCount_ff;
		if (wrCount)
			nxt_remainingCount = regWdata;
		else if (unitDone)
			nxt_remainingCount = remainingCount_ff - `DMACC_COUNT_ONE;
	end

	// end flag: set only on normal last unit, cleared by read-1-write-0
	always @* begin
		nxt_transferEndFlag = transferEndFlag_ff;
		nxt_endReadArmed    = endReadArmed_ff;
		if (rdCtrl && transferEndFlag_ff)
			nxt_endReadArmed = 1'b1;
		if (wrCtrl) begin
			nxt_endReadArmed = 1'b0;
			if (endReadArmed_ff && !regWdata[`DMACC_BIT_TE])
				nxt_transferEndFlag = 1'b0;
		end
		// set wins over a clear in the same cycle; aborts never get here
		if (unitDone && lastUnit)
			nxt_transferEndFlag = 1'b1;
	end

	// ack pin phase from the next state, polarity applied last
	always @* begin
		nxt_ack = 1'b0;
		if (srcExt) begin
			if (srcSingle)
				nxt_ack = (nxt_state == `DMACC_ST_SGL);
			else if (ackPhaseSel_ff)
				nxt_ack = (nxt_state == `DMACC_ST_WR);
			else
				nxt_ack = (nxt_state == `DMACC_ST_RD);
		end
		nxt_ack = nxt_ack ^ ackPolarity_ff;
	end

	// read data; unmapped offsets answer zero
	always @* begin
		nxt_rdata = 16'h0000;
		if (rdCtrl)
			nxt_rdata = ctrlView;
		else if (rdCount)
			nxt_rdata = remainingCount_ff;
	end

	// control register and sequencer state; standby acts as reset
	always @(posedge mclk) begin
		if (!rst_n || standby) begin
			requestSourceSel_ff    <= `DMACC_RS_EXT_DUAL;
			ackPhaseSel_ff         <= 1'b0;
			ackPolarity_ff         <= 1'b0;
			requestSenseSel_ff     <= 1'b0;
			busHoldSel_ff          <= 1'b0;
			unitSizeSel_ff         <= 1'b0;
			completionIrqEnable_ff <= 1'b0;
			transferEndFlag_ff     <= 1'b0;
			channelEnable_ff       <= 1'b0;
			endReadArmed_ff        <= 1'b0;
			remainingCount_ff      <= `DMACC_COUNT_RESET;
			state_ff               <= `DMACC_ST_IDLE;
		end else begin
			requestSourceSel_ff <= nxt_requestSourceSel;
			transferEndFlag_ff  <= nxt_transferEndFlag;
			endReadArmed_ff     <= nxt_endReadArmed;
			remainingCount_ff   <= nxt_remainingCount;
			state_ff            <= nxt_state;
			if (wrCtrl) begin
				// pin-related bits stay zero where there is no pin
				if (EXT_OK != 0) begin
					ackPhaseSel_ff     <= regWdata[`DMACC_BIT_AM];
					ackPolarity_ff     <= regWdata[`DMACC_BIT_AL];
					requestSenseSel_ff <= regWdata[`DMACC_BIT_DS];
				end
				busHoldSel_ff          <= regWdata[`DMACC_BIT_TM];
				unitSizeSel_ff         <= regWdata[`DMACC_BIT_TS];
				completionIrqEnable_ff <= regWdata[`DMACC_BIT_IE];
				channelEnable_ff       <= regWdata[`DMACC_BIT_DE];
			end
		end
	end

	// registered outputs toward bus, pins and interrupt controller
	always @(posedge mclk) begin
		if (!rst_n || standby) begin
			regRdata     <= 16'h0000;
			extXferAck   <= 1'b0;
			busOwn       <= 1'b0;
			readCycle    <= 1'b0;
			writeCycle   <= 1'b0;
			singleAddr   <= 1'b0;
			wordUnit     <= 1'b0;
			burstHold    <= 1'b0;
			blockDoneIrq <= 1'b0;
		end else begin
			regRdata   <= nxt_rdata;
			extXferAck <= nxt_ack;
			busOwn     <= (nxt_state != `DMACC_ST_IDLE);
			readCycle  <= (nxt_state == `DMACC_ST_RD);
			writeCycle <= (nxt_state == `DMACC_ST_WR);
			singleAddr <= (nxt_state == `DMACC_ST_SGL);
			// size and mode describe the unit on the bus only
			wordUnit   <= (nxt_state != `DMACC_ST_IDLE) & unitSizeSel_ff;
			burstHold  <= (nxt_state != `DMACC_ST_IDLE) & busHoldSel_ff;
			// level interrupt, follows the flag the same edge it sets
			blockDoneIrq <= completionIrqEnable_ff & nxt_transferEndFlag;
		end
	end

endmodule

`default_nettype wire

// ### test/dmacc_far_model.sv
// far side model: a requesting device on the pin, dropping its request per ack
// assumes ack polarity from the bench and the channel's registered ack output
`default_nettype none
module dmacc_far_model (
	input  wire logic mclk,
	input  wire logic reqOn,
	input  wire logic relOnAck,
	input  wire logic ackActiveLow,
	input  wire logic ack,
	output var  logic extReq_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gap_ff = 1'b0;
	logic ackOn;
	assign ackOn = relOnAck && (ack ^ ackActiveLow);
	initial extReq_n = 1'b1;
	// active-low request; a release through each ack and one cycle after it gives fresh falling edges
	always @(posedge mclk) begin
		gap_ff   <= ackOn;
		extReq_n <= !(reqOn && !gap_ff && !ackOn);
	end
endmodule
`default_nettype wire

// ### test/dmacc_channel_checker.sv
// port-level assertions for one dma channel control block
// assumes one clock, sync active-low reset and standby acting as reset
`default_nettype none
module dmacc_channel_checker (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        standby,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [15:0] regRdata,
	input wire logic        globalXferEnable,
	input wire logic        nmiAbortFlag,
	input wire logic        addrFaultFlag,
	input wire logic        busOwn,
	input wire logic        readCycle,
	input wire logic        writeCycle,
	input wire logic        singleAddr,
	input wire logic        wordUnit,
	input wire logic        burstHold,
	input wire logic        blockDoneIrq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n || standby);
	// dual units: one read cycle then exactly one write cycle
	// an abort in the read cycle legally ends the unit early, so it is excluded
	dual_order_a: assert property ($rose(readCycle) && globalXferEnable && !nmiAbortFlag &&
		!addrFaultFlag && !$past(regWr) |=> writeCycle && !readCycle)
		else $error("write cycle did not follow read cycle");
	dual_excl_a: assert property (!(readCycle && (writeCycle || singleAddr)))
		else $error("read cycle overlaps another cycle kind");
	cycle_own_a: assert property ((writeCycle || singleAddr || wordUnit || burstHold) |-> busOwn)
		else $error("unit qualifier without bus ownership");
	// cycle-steal must hand the bus back after every unit
	steal_gap_a: assert property (busOwn && !burstHold && (writeCycle || singleAddr) |=> !busOwn)
		else $error("bus kept after unit in cycle-steal");
	global_abort_a: assert property (!globalXferEnable |=> !busOwn)
		else $error("bus owned after global enable dropped");
	fault_block_a: assert property ((nmiAbortFlag || addrFaultFlag) |=> !busOwn)
		else $error("bus owned while abort flag set");
	irq_fall_a: assert property ($fell(blockDoneIrq) |-> $past(regWr))
		else $error("completion irq dropped without a write");
	// flag rises only at the edge ending a unit, irq may follow an enable write
	irq_rise_a: assert property ($rose(blockDoneIrq) |->
		$past(regWr) || $past(writeCycle) || $past(singleAddr))
		else $error("completion irq rose outside unit end");
	rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
		else $error("read data not zero outside read answer");
	cover property ($rose(readCycle));
	cover property ($rose(singleAddr));
	cover property ($rose(blockDoneIrq));
	cover property ($fell(busOwn) && !globalXferEnable);
endmodule
bind dmacc_channel dmacc_channel_checker i_dmacc_channel_checker (.mclk(mclk), .rst_n(rst_n),
	.standby(standby), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.globalXferEnable(globalXferEnable), .nmiAbortFlag(nmiAbortFlag),
	.addrFaultFlag(addrFaultFlag), .busOwn(busOwn), .readCycle(readCycle),
	.writeCycle(writeCycle), .singleAddr(singleAddr), .wordUnit(wordUnit),
	.burstHold(burstHold), .blockDoneIrq(blockDoneIrq));
`default_nettype wire

// ### test/dmacc_channel_tb.sv
// self-checking bench for one dma channel (channel 0, pin features present)
// assumes the far-side model on the request pin; peripheral lines driven here
`include "dmacc_consts.vh"
`default_nettype none
module dmacc_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, rst_n = 0, standby = 0, regWr = 0, regRd = 0, rdSeen = 0;
	logic [7:0]  regAddr = 0;
	logic [15:0] regWdata = 0, regRdata;
	logic        gEn = 0, nmi = 0, fault = 0, reqOn = 0, relOn = 1, extReq_n;
	logic [8:0]  periph = 0;
	logic        ack, busOwn, rdC, wrC, sgl, wordU, burst, irq;
	logic        tExt = 0, tSgl = 0, tAm = 0, tAl = 0, tWs = 0, tTm = 0;
	logic [3:0]  code;
	logic [3:0]  rsv [3] = '{4'h1, 4'he, 4'hf};
	logic [15:0] expQ [$];
	int          fails = 0, n_compared = 0, seed = 32'h3184;
	dmacc_channel #(.CH_NUM(0)) i_dmacc_channel (.mclk(mclk), .rst_n(rst_n), .standby(standby),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .globalXferEnable(gEn), .nmiAbortFlag(nmi),
		.addrFaultFlag(fault), .extXferRequest_n(extReq_n), .serial0RxFullReq(periph[0]),
		.serial0TxEmptyReq(periph[1]), .serial1RxFullReq(periph[2]),
		.serial1TxEmptyReq(periph[3]), .timer0MatchAReq(periph[4]),
		.timer1MatchAReq(periph[5]), .timer2MatchAReq(periph[6]),
		.timer3MatchAReq(periph[7]), .convDoneReq(periph[8]), .extXferAck(ack),
		.busOwn(busOwn), .readCycle(rdC), .writeCycle(wrC), .singleAddr(sgl),
		.wordUnit(wordU), .burstHold(burst), .blockDoneIrq(irq));
	dmacc_far_model i_dmacc_far_model (.mclk(mclk), .reqOn(reqOn), .relOnAck(relOn),
		.ackActiveLow(tAl), .ack(ack), .extReq_n(extReq_n));
	initial forever #2 mclk = ~mclk;
	task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmpBit(input logic got, input logic exp);
		cmpWord({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic close_out();
		if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// register bus: one-cycle strobes launched just after the edge
	task automatic wr(input logic cnt, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= cnt ? `DMACC_OFS_COUNT : `DMACC_OFS_CTRL;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		// remember size and bus mode for the per-unit qualifier checks
		if (!cnt) begin
			tWs <= d[`DMACC_BIT_TS];
			tTm <= d[`DMACC_BIT_TM];
		end
	endtask
	task automatic rd(input logic cnt, input logic [15:0] e);
		@(posedge mclk);
		regAddr <= cnt ? `DMACC_OFS_COUNT : `DMACC_OFS_CTRL;
		regRd <= 1'b1;
		expQ.push_back(e);
		@(posedge mclk);
		regRd <= 1'b0;
	endtask
	task automatic waitIrq();
		for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge mclk);
		cmpBit(irq, 1'b1);
	endtask
	// read answers taken mid-cycle after the strobe; ack level checked per unit cycle
	always @(posedge mclk) rdSeen <= regRd;
	always @(negedge mclk) begin
		if (rdSeen) cmpWord(regRdata, expQ.pop_front());
		if (busOwn === 1'b1) begin
			cmpBit(ack, tAl ^ (tExt && (tSgl ? sgl : tAm ? wrC : rdC)));
			cmpBit(wordU, tWs);
			cmpBit(burst, tTm);
		end
	end
	initial begin
		#80000;
		fails++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		gEn <= 1'b1;
		rd(0, 16'h0000);
		rd(1, 16'h0000);
		// auto burst word, two units; then the end flag blocks a new enable
		wr(1, 16'h0002);
		wr(0, 16'h0c1d);
		waitIrq();
		rd(1, 16'h0000);
		wr(0, 16'h0c1f);
		repeat (8) @(posedge mclk);
		rd(1, 16'h0000);
		wr(0, 16'h0c04);
		rd(0, 16'h0c06);
		wr(0, 16'h0c04);
		rd(0, 16'h0c04);
		// each peripheral source: others random and target low must not start
		for (int k = 0; k < 9; k++) begin
			code = (k == 8) ? 4'hd : 4'(k + 4);
			periph <= 9'($random(seed)) & ~(9'h001 << k);
			wr(1, 16'h0001);
			wr(0, {4'h0, code, 8'h05});
			repeat (6) @(posedge mclk);
			rd(1, 16'h0001);
			periph <= periph | (9'h001 << k);
			waitIrq();
			rd(0, {4'h0, code, 8'h07});
			wr(0, {4'h0, code, 8'h04});
		end
		// reserved codes stay idle with every request present
		periph <= 9'h1ff;
		reqOn <= 1'b1;
		foreach (rsv[j]) begin
			wr(1, 16'h0001);
			wr(0, {4'h0, rsv[j], 8'h01});
			repeat (8) @(posedge mclk);
			rd(1, 16'h0001);
		end
		// pin, dual, ack in write cycle, active high, level sense
		tExt <= 1'b1;
		tAm <= 1'b1;
		wr(1, 16'h0002);
		wr(0, 16'h0085);
		waitIrq();
		rd(1, 16'h0000);
		rd(0, 16'h0087);
		wr(0, 16'h0004);
		// pin, single address both ways, active-low ack
		tSgl <= 1'b1;
		tAl <= 1'b1;
		for (int j = 2; j < 4; j++) begin
			wr(1, 16'h0002);
			wr(0, {4'h0, 4'(j), 8'h45});
			waitIrq();
			rd(0, {4'h0, 4'(j), 8'h47});
			wr(0, 16'h0004);
		end
		// falling-edge sense: one held-low request gives one unit only
		reqOn <= 1'b0;
		relOn <= 1'b0;
		tSgl <= 1'b0;
		tAm <= 1'b0;
		tAl <= 1'b0;
		wr(1, 16'h0003);
		wr(0, 16'h0021);
		reqOn <= 1'b1;
		repeat (20) @(posedge mclk);
		rd(1, 16'h0002);
		wr(0, 16'h0000);
		// aborts by global enable and nmi leave the end flag clear
		tExt <= 1'b0;
		wr(1, 16'h0000);
		wr(0, 16'h0c01);
		repeat (10) @(posedge mclk);
		gEn <= 1'b0;
		repeat (4) @(posedge mclk);
		rd(0, 16'h0c01);
		gEn <= 1'b1;
		repeat (10) @(posedge mclk);
		nmi <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(0, 16'h0c01);
		nmi <= 1'b0;
		repeat (10) @(posedge mclk);
		wr(0, 16'h0c00);
		rd(0, 16'h0c00);
		// standby clears like reset, count left nonzero by the abort
		wr(0, 16'h0c1d);
		standby <= 1'b1;
		@(posedge mclk);
		standby <= 1'b0;
		rd(0, 16'h0000);
		rd(1, 16'h0000);
		repeat (3) @(posedge mclk);
		close_out();
	end
endmodule
`default_nettype wire
